// file: sim/cfv_ctl_model.sv
// controller-side model: filter hits, compare operands, interrupt sources
`timescale 1ns/10ps
`include "cfv_defs.svh"
module cfv_ctl_model (
  // clock
  input  wire logic                   mclk,
  // acceptance filter side
  output logic                        filter_hit_valid,
  output logic [3:0]                  filter_hit_num,
  output logic [`CFV_EID_W-1:0]       rx_data_lead_bits,
  output logic [`CFV_EID_W-1:0]       extended_identifier_bits,
  // sources: err, wake, ovf, fifo from msb down
  output logic [3:0]                  src_pend,
  output logic [`CFV_NUM_RB-1:0]      rx_buf_pend
);
  // ==========================================================
  // idle values at time zero
  initial begin
    filter_hit_valid = 1'b0;
    filter_hit_num = 4'hF;
    rx_data_lead_bits = '0;
    extended_identifier_bits = '0;
    src_pend = 4'h0;
    rx_buf_pend = '0;
  end
  // one-cycle hit pulse; only 16 filters exist, so number stays 4 bits
  task automatic hit(input logic [3:0] n);
    @(posedge mclk);
    filter_hit_valid <= 1'b1;
    filter_hit_num <= n;
    @(posedge mclk);
    filter_hit_valid <= 1'b0;
    filter_hit_num <= ~n; // stale number must not be trusted
  endtask
  // pending source levels
  task automatic set_src(input logic [3:0] s, input logic [15:0] rb);
    @(posedge mclk);
    src_pend <= s;
    rx_buf_pend <= rb;
  endtask
  // leading data bits and filter identifier bits
  task automatic set_bits(input logic [17:0] d, input logic [17:0] e);
    @(posedge mclk);
    rx_data_lead_bits <= d;
    extended_identifier_bits <= e;
  endtask
endmodule

// file: sim/cfv_top_tb_top.sv
// self-checking bench for the filter-hit and interrupt-code block
`timescale 1ns/10ps
`include "cfv_defs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module cfv_top_tb_top;
  // ==========================================================
  // signals
  logic        mclk, rst_n, read, write, waitrequest, data_cmp_match, irq;
  logic        hv;
  logic [3:0]  hn, sp;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [17:0] dl, eb;
  logic [15:0] rbp;
  int          n_fail, compares, i;
  logic [4:0]  c_cnt [7] = '{5'h00, 5'h01, 5'h01, 5'h09, 5'h09, 5'h11, 5'h11};
  logic [17:0] c_dat [7] = '{18'h3FFFF, 18'h1, 18'h2, 18'h100, 18'h200, 18'h10000, 18'h20000};
  logic        c_exp [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [3:0]  s_src [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
  logic [15:0] s_rb  [6] = '{16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'hFFFF, 16'h8001};
  logic [6:0]  s_exp [6] = '{7'h44, 7'h43, 7'h42, 7'h41, 7'h41, 7'h00};
  // ==========================================================
  // design and controller model
  cfv_top u_dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .filter_hit_valid(hv), .filter_hit_num(hn), .rx_data_lead_bits(dl),
    .extended_identifier_bits(eb), .data_cmp_match(data_cmp_match), .rx_buf_pend(rbp),
    .err_pend(sp[3]), .wake_pend(sp[2]), .ovf_pend(sp[1]), .fifo_pend(sp[0]), .irq(irq));
  cfv_ctl_model u_ctl (.mclk(mclk), .filter_hit_valid(hv), .filter_hit_num(hn),
    .rx_data_lead_bits(dl), .extended_identifier_bits(eb), .src_pend(sp), .rx_buf_pend(rbp));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ==========================================================
  // verdict
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one avalon access; the request is held until the rising edge at which
  // waitrequest is sampled low, and read data is taken at that same edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge mclk);
    `CHK(irq, exp)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, unimplemented bits and unmapped place
    rd_chk(`CFV_OFS_VEC, 32'h00000040);
    rd_chk(`CFV_OFS_CTL, 32'h0);
    rd_chk(8'h14, 32'h0);
    bus(1'b1, `CFV_OFS_CTL, 32'hFFFFFFF1);
    rd_chk(`CFV_OFS_CTL, 32'h00000011);
    // compare count: counts 0x12 to 0x1F are never written by software
    for (i = 0; i < 7; i++) begin
      bus(1'b1, `CFV_OFS_CTL, {27'h0, c_cnt[i]});
      u_ctl.set_bits(c_dat[i], 18'h0);
      @(posedge mclk);
      @(negedge mclk);
      `CHK(data_cmp_match, c_exp[i])
    end
    // buffer codes, each buffer alone
    for (i = 0; i < 16; i++) begin
      u_ctl.set_src(4'h0, 16'h1 << i);
      rd_chk(`CFV_OFS_VEC, i);
    end
    // priority among sources, then back to none
    for (i = 0; i < 6; i++) begin
      u_ctl.set_src(s_src[i], s_rb[i]);
      rd_chk(`CFV_OFS_VEC, {25'h0, s_exp[i]});
    end
    u_ctl.set_src(4'h0, 16'h0);
    rd_chk(`CFV_OFS_VEC, 32'h00000040);
    // every filter number
    for (i = 0; i < 16; i++) begin
      u_ctl.hit(i[3:0]);
      rd_chk(`CFV_OFS_VEC, (i << 8) | 32'h40);
    end
    // interrupt: clear, raise, mask, clear, second event
    bus(1'b1, `CFV_OFS_IRQ_EN, 32'h3);
    bus(1'b1, `CFV_OFS_IRQ_CLR, 32'h3);
    rd_chk(`CFV_OFS_IRQ_STS, 32'h0);
    irq_chk(1'b0);
    u_ctl.hit(4'h5);
    rd_chk(`CFV_OFS_IRQ_STS, 32'h1);
    irq_chk(1'b1);
    bus(1'b1, `CFV_OFS_IRQ_STS, 32'h0); // read-only, write ignored
    rd_chk(`CFV_OFS_IRQ_STS, 32'h1);
    bus(1'b1, `CFV_OFS_IRQ_EN, 32'h2);
    irq_chk(1'b0);
    rd_chk(`CFV_OFS_IRQ_EN, 32'h2);
    rd_chk(`CFV_OFS_IRQ_CLR, 32'h0);
    bus(1'b1, `CFV_OFS_IRQ_CLR, 32'h1);
    rd_chk(`CFV_OFS_IRQ_STS, 32'h0);
    u_ctl.set_src(4'h8, 16'h0);
    rd_chk(`CFV_OFS_IRQ_STS, 32'h2);
    irq_chk(1'b1);
    rd_chk(`CFV_OFS_VEC, 32'h00000541);
    // clear and filter hit land on one edge: the hit survives, bit1 clears
    fork
      bus(1'b1, `CFV_OFS_IRQ_CLR, 32'h3);
      begin
        @(posedge mclk);
        u_ctl.hit(4'h3);
      end
    join
    rd_chk(`CFV_OFS_IRQ_STS, 32'h1);
    end_of_test();
  end
endmodule

// file: verilog/cfv_bitcmp.sv
// comparator of leading data bits against filter identifier bits
`timescale 1ns/10ps
`include "cfv_defs.svh"
module cfv_bitcmp (
  // comparison operands and result
  cfv_cmp_if.cmp cp
);
  wire [`CFV_EID_W-1:0] use_bit;
  wire [`CFV_EID_W-1:0] bit_ok;
  // ===========================================================================
  // per-bit mask: bit i takes part when i is below the count
  genvar gi;
  generate
    for (gi = 0; gi < `CFV_EID_W; gi = gi + 1) begin : g_bit
      assign use_bit[gi] = (`CFV_CNT_W'(gi) < cp.cnt);
      assign bit_ok[gi]  = ~use_bit[gi] | (cp.data_bits[gi] == cp.eid_bits[gi]);
    end
  endgenerate
  // a count of zero masks every bit, so the data never blocks a match
  assign cp.match = &bit_ok;
endmodule

// file: verilog/cfv_cmp_if.sv
// carrier between the register block and the data-bit comparator
`timescale 1ns/10ps
`include "cfv_defs.svh"
interface cfv_cmp_if;
  logic [`CFV_CNT_W-1:0] cnt;
  logic [`CFV_EID_W-1:0] data_bits;
  logic [`CFV_EID_W-1:0] eid_bits;
  logic                  match;
  modport ctl (output cnt, output data_bits, output eid_bits, input match);
  modport cmp (input cnt, input data_bits, input eid_bits, output match);
endinterface

// file: verilog/cfv_defs.svh
// constants for the filter-hit and interrupt-code block
`ifndef CFV_DEFS_SVH
`define CFV_DEFS_SVH
// ===========================================================================
// register byte offsets
`define CFV_OFS_VEC      8'h00
`define CFV_OFS_CTL      8'h04
`define CFV_OFS_IRQ_STS  8'h08
`define CFV_OFS_IRQ_CLR  8'h0C
`define CFV_OFS_IRQ_EN   8'h10
// ===========================================================================
// field positions in the vector status register
`define CFV_VEC_HIT_LSB  8
`define CFV_VEC_HIT_MSB  12
`define CFV_VEC_CODE_MSB 6
// ===========================================================================
// interrupt source codes
`define CFV_CODE_NONE    7'h40
`define CFV_CODE_ERR     7'h41
`define CFV_CODE_WAKE    7'h42
`define CFV_CODE_OVF     7'h43
`define CFV_CODE_FIFO    7'h44
// ===========================================================================
// widths and reset values
`define CFV_CNT_W        5
`define CFV_EID_W        18
`define CFV_NUM_RB       16
`define CFV_CNT_RST      5'h00
`define CFV_HIT_RST      5'h00
`define CFV_IRQ_W        2
`define CFV_IRQ_HIT      0
`define CFV_IRQ_SRC      1
`endif

// file: verilog/cfv_interrupt_source_code_enc.sv
// priority encoder for the interrupt source code
`timescale 1ns/10ps
`include "cfv_defs.svh"
module cfv_interrupt_source_code_enc (
  // pending sources
  input  wire logic                    err_pend,
  input  wire logic                    wake_pend,
  input  wire logic                    ovf_pend,
  input  wire logic                    fifo_pend,
  input  wire logic [`CFV_NUM_RB-1:0]  rb_pend,
  // encoded result
  output logic      [6:0]              code
);
  // ===========================================================================
  // lowest buffer number wins among buffers; specials beat all buffers
  always_comb begin
    code = `CFV_CODE_NONE;
    for (int i = `CFV_NUM_RB - 1; i >= 0; i--) begin
      if (rb_pend[i]) begin
        code = 7'(i);
      end
    end
    if (fifo_pend) begin
      code = `CFV_CODE_FIFO;
    end
    if (ovf_pend) begin
      code = `CFV_CODE_OVF;
    end
    if (wake_pend) begin
      code = `CFV_CODE_WAKE;
    end
    if (err_pend) begin
      code = `CFV_CODE_ERR;
    end
  end
endmodule

// file: verilog/cfv_pkg.sv
// types shared by the filter-hit and interrupt-code block
package cfv_pkg;
  // bus slave states, one-hot
  typedef enum logic [1:0] {
    CFV_ST_IDLE = 2'b01,
    CFV_ST_ACK  = 2'b10
  } cfv_bus_st_t;
endpackage

// file: verilog/cfv_top.sv
// filter-hit report, interrupt code and data-bit compare count
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`include "cfv_defs.svh"
module cfv_top
  import cfv_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [7:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // acceptance filter side
  input  wire logic                   filter_hit_valid,
  input  wire logic [3:0]             filter_hit_num,
  input  wire logic [`CFV_EID_W-1:0]  rx_data_lead_bits,
  input  wire logic [`CFV_EID_W-1:0]  extended_identifier_bits,
  output logic                        data_cmp_match,
  // interrupt sources from the controller
  input  wire logic [`CFV_NUM_RB-1:0] rx_buf_pend,
  input  wire logic                   err_pend,
  input  wire logic                   wake_pend,
  input  wire logic                   ovf_pend,
  input  wire logic                   fifo_pend,
  // interrupt line
  output logic                        irq
);
  cfv_bus_st_t                 st_ff;
  cfv_bus_st_t                 nxt_st;
  logic [`CFV_CNT_W-1:0]       data_bit_compare_count_ff;
  logic [4:0]                  matched_filter_number_ff;
  logic [6:0]                  interrupt_source_code_ff;
  logic                        cmp_match_ff;
  logic [`CFV_IRQ_W-1:0]       irq_sts_ff;
  logic [`CFV_IRQ_W-1:0]       irq_en_ff;
  logic [31:0]                 rdata_ff;
  logic [6:0]                  nxt_code;
  logic [31:0]                 nxt_rdata;
  wire                         req;
  wire                         acc_done;
  wire                         wr_done;
  wire                         sel_vec;
  wire                         sel_ctl;
  wire                         sel_sts;
  wire                         sel_clr;
  wire                         sel_en;
  wire [15:0]                  vec_word;
  wire [`CFV_IRQ_W-1:0]        irq_evt;
  wire [`CFV_IRQ_W-1:0]        irq_clr;

  cfv_cmp_if cmp_bus ();

  // ===========================================================================
  // bus handshake: one wait cycle, answer on the second cycle
  assign req         = read | write;
  assign waitrequest = req & (st_ff != CFV_ST_ACK);
  assign acc_done    = req & (st_ff == CFV_ST_ACK);
  assign wr_done     = acc_done & write;
  assign readdata    = rdata_ff;

  // address decode; misaligned or unmapped reads give zero
  assign sel_vec = (address == `CFV_OFS_VEC);
  assign sel_ctl = (address == `CFV_OFS_CTL);
  assign sel_sts = (address == `CFV_OFS_IRQ_STS);
  assign sel_clr = (address == `CFV_OFS_IRQ_CLR);
  assign sel_en  = (address == `CFV_OFS_IRQ_EN);

  // vector word: bits 15:13 and 7 stay zero
  assign vec_word = {3'h0, matched_filter_number_ff, 1'h0, interrupt_source_code_ff};

  // read mux; clear register is write-only and reads zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel_vec) begin
      nxt_rdata = {16'h0000, vec_word};
    end else if (sel_ctl) begin
      nxt_rdata = {27'h000_0000, data_bit_compare_count_ff};
    end else if (sel_sts) begin
      nxt_rdata = {30'h0000_0000, irq_sts_ff};
    end else if (sel_en) begin
      nxt_rdata = {30'h0000_0000, irq_en_ff};
    end
  end

  // state step
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      CFV_ST_IDLE: begin
        if (req) begin
          nxt_st = CFV_ST_ACK;
        end
      end
      CFV_ST_ACK: begin
        nxt_st = CFV_ST_IDLE;
      end
      default: begin
        nxt_st = CFV_ST_IDLE;
      end
    endcase
  end

  // state and read data; data captured in the wait cycle so it stands at the ack edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= CFV_ST_IDLE;
      rdata_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      if (read & (st_ff == CFV_ST_IDLE)) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ===========================================================================
  // control register: the count steers the comparator
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_bit_compare_count_ff <= `CFV_CNT_RST;
      irq_en_ff                 <= '0;
    end else begin
      if (wr_done & sel_ctl) begin
        data_bit_compare_count_ff <= writedata[`CFV_CNT_W-1:0];
      end
      if (wr_done & sel_en) begin
        irq_en_ff <= writedata[`CFV_IRQ_W-1:0];
      end
    end
  end

  // ===========================================================================
  // data-bit comparison; counts past 10001 are not trapped and compare all 18
  assign cmp_bus.cnt       = data_bit_compare_count_ff;
  assign cmp_bus.data_bits = rx_data_lead_bits;
  assign cmp_bus.eid_bits  = extended_identifier_bits;

  cfv_bitcmp u_bitcmp (
    .cp (cmp_bus.cmp)
  );

  // registered so the filter sees a clean level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_match_ff <= 1'b1;
    end else begin
      cmp_match_ff <= cmp_bus.match;
    end
  end
  assign data_cmp_match = cmp_match_ff;

  // ===========================================================================
  // interrupt code and filter hit
  cfv_interrupt_source_code_enc u_interrupt_source_code_enc (
    .err_pend  (err_pend),
    .wake_pend (wake_pend),
    .ovf_pend  (ovf_pend),
    .fifo_pend (fifo_pend),
    .rb_pend   (rx_buf_pend),
    .code      (nxt_code)
  );

  // top bit of the hit field is held zero: filters 16 and up do not exist
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      matched_filter_number_ff <= `CFV_HIT_RST;
      interrupt_source_code_ff <= `CFV_CODE_NONE;
    end else begin
      if (filter_hit_valid) begin
        matched_filter_number_ff <= {1'b0, filter_hit_num};
      end
      interrupt_source_code_ff <= nxt_code;
    end
  end

  // ===========================================================================
  // sticky events: new filter hit, and a source appearing while none was shown
  assign irq_evt[`CFV_IRQ_HIT] = filter_hit_valid;
  assign irq_evt[`CFV_IRQ_SRC] = (nxt_code != `CFV_CODE_NONE) &
                                 (interrupt_source_code_ff == `CFV_CODE_NONE);
  assign irq_clr = (wr_done & sel_clr) ? writedata[`CFV_IRQ_W-1:0] : '0;

  // set wins over clear so a same-cycle event is never lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_ff <= '0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_evt;
    end
  end
  assign irq = |(irq_sts_ff & irq_en_ff);

  // ===========================================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_cnt_write: assert property (wr_done & sel_ctl |=>
    data_bit_compare_count_ff == $past(writedata[4:0]))
    else $error("compare count did not take the written value");
  a_zero_cnt_pass: assert property ((data_bit_compare_count_ff == 5'h00) |=>
    data_cmp_match)
    else $error("count zero must not block a match");
  a_one_bit_cmp: assert property ((data_bit_compare_count_ff == 5'h01) &&
    (rx_data_lead_bits[0] != extended_identifier_bits[0]) |=> !data_cmp_match)
    else $error("count one must compare the first data bit");
  a_hit_capture: assert property (filter_hit_valid |=>
    matched_filter_number_ff == {1'b0, $past(filter_hit_num)})
    else $error("filter hit number not captured");
  a_rb0_code: assert property (!err_pend && !wake_pend && !ovf_pend && !fifo_pend &&
    rx_buf_pend[0] |=> interrupt_source_code_ff == 7'h00)
    else $error("buffer 0 code wrong");
  a_receive_buffer_fifteen_code: assert property (!err_pend && !wake_pend && !ovf_pend && !fifo_pend &&
    (rx_buf_pend == 16'h8000) |=> interrupt_source_code_ff == 7'h0F)
    else $error("buffer 15 code wrong");
  a_vec_zero_bits: assert property (acc_done && read && sel_vec |->
    readdata[31:13] == 19'h0_0000 && !readdata[7])
    else $error("unimplemented vector bits not zero");
  a_code_none: assert property (!err_pend && !wake_pend && !ovf_pend && !fifo_pend &&
    (rx_buf_pend == 16'h0000) |=> interrupt_source_code_ff == 7'h40)
    else $error("idle code is not none");
  a_code_legal: assert property (interrupt_source_code_ff <= 7'h44 &&
    !(interrupt_source_code_ff inside {[7'h10:7'h3F]}))
    else $error("reserved interrupt code produced");
  a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest || !req)
    else $error("bus answer not within one wait cycle");

  // handshake: a stall only ever answers a request
  a_idle_no_wait: assert property (!req |-> !waitrequest)
    else $error("waitrequest raised with no request");

  // ===========================================================================
  // read-back of the narrow registers and the hit field
  a_ctl_zero_bits: assert property (acc_done && read && sel_ctl |->
    readdata[31:5] == 27'h000_0000)
    else $error("unimplemented control bits not zero");
  a_clr_reads_zero: assert property (acc_done && read && sel_clr |->
    readdata == 32'h0000_0000)
    else $error("write-only clear register did not read zero");
  a_hit_no_reserved: assert property (!matched_filter_number_ff[4])
    else $error("reserved filter hit code produced");

  // ===========================================================================
  // source priority and the widest legal compare count
  a_err_first: assert property (err_pend |=>
    interrupt_source_code_ff == `CFV_CODE_ERR)
    else $error("error source did not win priority");
  a_fifo_code: assert property (!err_pend && !wake_pend && !ovf_pend && fifo_pend |=>
    interrupt_source_code_ff == `CFV_CODE_FIFO)
    else $error("fifo almost full code wrong");
  a_cnt_max_cmp: assert property ((data_bit_compare_count_ff == 5'h11) &&
    (rx_data_lead_bits[16] != extended_identifier_bits[16]) |=> !data_cmp_match)
    else $error("count 17 must compare data bit 16");
  a_cnt_max_free: assert property ((data_bit_compare_count_ff == 5'h11) &&
    (rx_data_lead_bits[16:0] == extended_identifier_bits[16:0]) |=> data_cmp_match)
    else $error("count 17 must leave bit 17 out of the compare");

  // ===========================================================================
  // sticky status, clear and enable; the hit bit stands for both
  a_sts_set_wins: assert property (irq_evt[`CFV_IRQ_HIT] |=>
    irq_sts_ff[`CFV_IRQ_HIT])
    else $error("filter hit event lost against a clear");
  a_sts_clear: assert property (wr_done && sel_clr && writedata[0] && !filter_hit_valid |=>
    !irq_sts_ff[`CFV_IRQ_HIT])
    else $error("status clear had no effect");
  a_sts_hold: assert property (!irq_evt[`CFV_IRQ_HIT] && !(wr_done && sel_clr) |=>
    $stable(irq_sts_ff[`CFV_IRQ_HIT]))
    else $error("status bit changed without cause");
  a_en_write: assert property (wr_done && sel_en |=>
    irq_en_ff == $past(writedata[1:0]))
    else $error("enable register did not take the written value");

  // interrupt line follows enabled status only
  a_irq_masked: assert property ((irq_en_ff == 2'h0) |-> !irq)
    else $error("interrupt raised with every source masked");
  a_irq_enabled: assert property (irq_sts_ff[`CFV_IRQ_HIT] && irq_en_ff[`CFV_IRQ_HIT] |->
    irq)
    else $error("enabled status bit did not raise the interrupt");

  c_err_code: cover property (err_pend ##1 interrupt_source_code_ff == 7'h41);
  c_irq_raise: cover property (!irq ##1 irq);
  c_cnt_max: cover property (data_bit_compare_count_ff == 5'h11 && data_cmp_match);
  c_clr_and_set: cover property (wr_done && sel_clr && filter_hit_valid);
endmodule
